// File: src/tmcu_edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses for one pin.
// Assumes the pin is slower than half the core clock.
`timescale 1ns/1ps
module tmcu_edge_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin side
  input wire logic pin,
  // Edge pulses, one cycle each
  output logic rise,
  output logic fall
);
  import tmcu_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tmcu_sync_t;

  tmcu_sync_t s_q;
  tmcu_sync_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Only the second flop reads the first one; edges come from later stages
  always_comb begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.sync & ~s_q.prev;
  assign fall = ~s_q.sync & s_q.prev;

endmodule

// File: src/tmcu_pkg.sv
// Constants, register map and field layout of the match/capture timer.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
package tmcu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int TMCU_AW = 8;
  localparam int TMCU_DW = 32;
  localparam int TMCU_NMATCH = 4;
  localparam int TMCU_NCAP = 2;
  localparam int TMCU_NDMA = 2;
  localparam int TMCU_NPWM = 3;
  localparam int TMCU_NPIN = 3;
  localparam int TMCU_NIRQ = 6;
  localparam int TMCU_PERIOD_IDX = 3;
  localparam int TMCU_PIN_XCLK = 0;
  localparam int TMCU_PIN_CAP0 = 1;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TMCU_A_CTRL = 8'h00;
  localparam logic [7:0] TMCU_A_COUNT = 8'h04;
  localparam logic [7:0] TMCU_A_PRESCALE = 8'h08;
  localparam logic [7:0] TMCU_A_PRECOUNT = 8'h0C;
  localparam logic [7:0] TMCU_A_MATCH_CTRL = 8'h10;
  localparam logic [7:0] TMCU_A_OUT_CTRL = 8'h14;
  localparam logic [7:0] TMCU_A_CAP_CTRL = 8'h18;
  localparam logic [7:0] TMCU_A_PWM_CTRL = 8'h1C;
  localparam logic [7:0] TMCU_A_MATCH0 = 8'h20;
  localparam logic [7:0] TMCU_A_CAP0 = 8'h30;
  localparam logic [7:0] TMCU_A_IRQ_STAT = 8'h38;
  localparam logic [7:0] TMCU_A_IRQ_MASK = 8'h3C;
  localparam int TMCU_A_STEP = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TMCU_CT_EN = 0;
  localparam int TMCU_CT_RST = 1;
  localparam int TMCU_CT_CMODE = 2;
  localparam int TMCU_CT_XRISE = 3;
  localparam int TMCU_CT_XFALL = 4;
  localparam int TMCU_CT_W = 5;
  localparam int TMCU_MC_STRIDE = 3;
  localparam int TMCU_MC_INT = 0;
  localparam int TMCU_MC_RST = 1;
  localparam int TMCU_MC_STOP = 2;
  localparam int TMCU_MC_DMA = 12;
  localparam int TMCU_MC_W = 14;
  localparam int TMCU_OC_STRIDE = 2;
  localparam int TMCU_OC_W = 8;
  localparam int TMCU_OC_PINS = 8;
  localparam int TMCU_CC_STRIDE = 3;
  localparam int TMCU_CC_RISE = 0;
  localparam int TMCU_CC_FALL = 1;
  localparam int TMCU_CC_INT = 2;
  localparam int TMCU_CC_CLR_EN = 6;
  localparam int TMCU_CC_CLR_RISE = 7;
  localparam int TMCU_CC_CLR_FALL = 8;
  localparam int TMCU_CC_CLR_SEL = 9;
  localparam int TMCU_CC_W = 10;
  localparam int TMCU_IRQ_CAP = 4;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [31:0] TMCU_ZERO32 = 32'h0000_0000;
  localparam logic [31:0] TMCU_ONE32 = 32'h0000_0001;

  typedef enum logic [1:0] {
    TMCU_ACT_NONE,
    TMCU_ACT_LOW,
    TMCU_ACT_HIGH,
    TMCU_ACT_TOGGLE
  } tmcu_act_t;

endpackage

// File: src/tmcu_top.sv
// Match/capture timer: 32-bit count, 32-bit prescale, four match units,
// two capture inputs, match pins, PWM, DMA requests and one interrupt.
// Assumes pins slower than half the core clock and a one-cycle strobe register port.
//
// Function
// - 32-bit count advanced by 32-bit prescaler
// - Timer mode or external clock counter mode
// - Four matches, optional interrupt, keep counting
// - Stop-on-match halts count, optional interrupt
// - Reset-on-match zeroes count, optional interrupt
// - Shadowed match values, glitch-free PWM update
// - Match pins: low, high, toggle, none
// - Capture count on input edge, optional interrupt
// - Two matches raise timed DMA requests
// - Capture event may clear count and prescaler
// - PWM mode with up to three outputs
`timescale 1ns/1ps
module tmcu_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [tmcu_pkg::TMCU_AW-1:0] reg_addr,
  input wire logic [tmcu_pkg::TMCU_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tmcu_pkg::TMCU_DW-1:0] reg_rdata,
  // Pins
  input wire logic ext_clk_in,
  input wire logic [tmcu_pkg::TMCU_NCAP-1:0] cap_in,
  output logic [tmcu_pkg::TMCU_NMATCH-1:0] match_out,
  // DMA handshake
  output logic [tmcu_pkg::TMCU_NDMA-1:0] dma_req,
  input wire logic [tmcu_pkg::TMCU_NDMA-1:0] dma_ack,
  // Interrupt
  output logic irq
);
  import tmcu_pkg::*;

  typedef struct packed {
    logic [TMCU_CT_W-1:0] ctrl;
    logic [31:0] count;
    logic [31:0] prescale;
    logic [31:0] precount;
    logic [TMCU_MC_W-1:0] mctrl;
    logic [TMCU_OC_W-1:0] octrl;
    logic [TMCU_CC_W-1:0] cctrl;
    logic [TMCU_NPWM-1:0] pwm;
    logic [TMCU_NMATCH-1:0][31:0] mshadow;
    logic [TMCU_NMATCH-1:0][31:0] mactive;
    logic [TMCU_NCAP-1:0][31:0] cap;
    logic [TMCU_NIRQ-1:0] stat;
    logic [TMCU_NIRQ-1:0] mask;
    logic [TMCU_NMATCH-1:0] mout;
    logic [TMCU_NDMA-1:0] dma;
    logic irq;
    logic [31:0] rdata;
  } tmcu_state_t;

  tmcu_state_t s_q;
  tmcu_state_t s_d;

  logic [TMCU_NPIN-1:0] pin_raw;
  logic [TMCU_NPIN-1:0] pin_rise;
  logic [TMCU_NPIN-1:0] pin_fall;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Edge qualifier shared by counting, capture and clear
  function automatic logic edge_hit(input logic r, input logic f,
                                    input logic sel_r, input logic sel_f);
    edge_hit = (r & sel_r) | (f & sel_f);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {cap_in, ext_clk_in};

  generate
    for (genvar g = 0; g < TMCU_NPIN; g++) begin : g_sync
      tmcu_edge_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin(pin_raw[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic src;
    logic tick;
    logic pwm_on;
    logic period_rst;
    logic rst_any;
    logic stop_any;
    logic clr;
    logic clr_ch;
    logic wr_stat;
    logic [TMCU_NMATCH-1:0] hit;
    logic [TMCU_NIRQ-1:0] set;
    logic [1:0] act;
    int cidx;
    src = 1'b0;
    tick = 1'b0;
    pwm_on = 1'b0;
    period_rst = 1'b0;
    rst_any = 1'b0;
    stop_any = 1'b0;
    clr = 1'b0;
    clr_ch = 1'b0;
    wr_stat = 1'b0;
    hit = '0;
    set = '0;
    act = 2'h0;
    cidx = 0;
    s_d = s_q;

    // Configuration writes
    if (reg_wr) begin
      case (reg_addr)
        TMCU_A_CTRL: s_d.ctrl = reg_wdata[TMCU_CT_W-1:0];
        TMCU_A_PRESCALE: s_d.prescale = reg_wdata;
        TMCU_A_MATCH_CTRL: s_d.mctrl = reg_wdata[TMCU_MC_W-1:0];
        TMCU_A_OUT_CTRL: s_d.octrl = reg_wdata[TMCU_OC_W-1:0];
        TMCU_A_CAP_CTRL: s_d.cctrl = reg_wdata[TMCU_CC_W-1:0];
        TMCU_A_PWM_CTRL: s_d.pwm = reg_wdata[TMCU_NPWM-1:0];
        TMCU_A_IRQ_MASK: s_d.mask = reg_wdata[TMCU_NIRQ-1:0];
        TMCU_A_IRQ_STAT: wr_stat = 1'b1;
        default: begin
        end
      endcase
      for (int i = 0; i < TMCU_NMATCH; i++) begin
        if (reg_addr == 8'(TMCU_A_MATCH0 + TMCU_A_STEP * i)) begin
          s_d.mshadow[i] = reg_wdata;
        end
      end
    end

    // Count source: every clock, or a chosen edge of the external clock
    src = s_q.ctrl[TMCU_CT_CMODE] ?
          edge_hit(pin_rise[TMCU_PIN_XCLK], pin_fall[TMCU_PIN_XCLK],
                   s_q.ctrl[TMCU_CT_XRISE], s_q.ctrl[TMCU_CT_XFALL]) :
          1'b1;

    if (s_q.ctrl[TMCU_CT_RST]) begin
      s_d.count = TMCU_ZERO32;
      s_d.precount = TMCU_ZERO32;
    end else if (s_q.ctrl[TMCU_CT_EN] && src) begin
      if (s_q.precount == s_q.prescale) begin
        s_d.precount = TMCU_ZERO32;
        tick = 1'b1;
      end else begin
        s_d.precount = 32'(s_q.precount + TMCU_ONE32);
      end
    end

    // Match compare only on a count step, so a halted count stays quiet
    pwm_on = |s_q.pwm;
    for (int i = 0; i < TMCU_NMATCH; i++) begin
      hit[i] = tick && (s_q.count == s_q.mactive[i]);
      if (hit[i] && s_q.mctrl[TMCU_MC_STRIDE * i + TMCU_MC_INT]) begin
        set[i] = 1'b1;
      end
      if (hit[i] && s_q.mctrl[TMCU_MC_STRIDE * i + TMCU_MC_RST]) begin
        rst_any = 1'b1;
      end
      if (hit[i] && s_q.mctrl[TMCU_MC_STRIDE * i + TMCU_MC_STOP]) begin
        stop_any = 1'b1;
      end
    end
    period_rst = pwm_on && hit[TMCU_PERIOD_IDX];

    if (tick) begin
      if (rst_any || period_rst) begin
        s_d.count = TMCU_ZERO32;
      end else if (!stop_any) begin
        s_d.count = 32'(s_q.count + TMCU_ONE32);
      end
    end
    if (stop_any) begin
      s_d.ctrl[TMCU_CT_EN] = 1'b0;
    end

    // Shadow values move in only at a period boundary or while the count reset bit is held, while PWM runs
    if (!pwm_on || period_rst || s_q.ctrl[TMCU_CT_RST]) begin
      s_d.mactive = s_q.mshadow;
    end

    // Match pins
    for (int i = 0; i < TMCU_NMATCH; i++) begin
      act = s_q.octrl[TMCU_OC_STRIDE * i +: 2];
      if (i < TMCU_NPWM && s_q.pwm[i]) begin
        if (period_rst) begin
          s_d.mout[i] = 1'b0;
        end else if (hit[i]) begin
          s_d.mout[i] = 1'b1;
        end
      end else if (hit[i]) begin
        case (tmcu_act_t'(act))
          TMCU_ACT_LOW: s_d.mout[i] = 1'b0;
          TMCU_ACT_HIGH: s_d.mout[i] = 1'b1;
          TMCU_ACT_TOGGLE: s_d.mout[i] = ~s_q.mout[i];
          default: s_d.mout[i] = s_q.mout[i];
        endcase
      end
    end

    // DMA requests stand until acknowledged; a new match wins over ack
    for (int k = 0; k < TMCU_NDMA; k++) begin
      s_d.dma[k] = (s_q.dma[k] & ~dma_ack[k]) |
                   (hit[k] & s_q.mctrl[TMCU_MC_DMA + k]);
    end

    // Capture snapshots the count as it stood in the edge cycle
    for (int j = 0; j < TMCU_NCAP; j++) begin
      if (edge_hit(pin_rise[TMCU_PIN_CAP0 + j], pin_fall[TMCU_PIN_CAP0 + j],
                   s_q.cctrl[TMCU_CC_STRIDE * j + TMCU_CC_RISE],
                   s_q.cctrl[TMCU_CC_STRIDE * j + TMCU_CC_FALL])) begin
        s_d.cap[j] = s_q.count;
        set[TMCU_IRQ_CAP + j] = s_q.cctrl[TMCU_CC_STRIDE * j + TMCU_CC_INT];
      end
    end

    // Clear on a designated capture edge wins over counting
    clr_ch = s_q.cctrl[TMCU_CC_CLR_SEL];
    cidx = TMCU_PIN_CAP0 + int'(clr_ch);
    clr = s_q.cctrl[TMCU_CC_CLR_EN] &&
          edge_hit(pin_rise[cidx], pin_fall[cidx],
                   s_q.cctrl[TMCU_CC_CLR_RISE], s_q.cctrl[TMCU_CC_CLR_FALL]);
    if (clr) begin
      s_d.count = TMCU_ZERO32;
      s_d.precount = TMCU_ZERO32;
    end

    // Software load of the count goes last so it is never lost
    if (reg_wr && reg_addr == TMCU_A_COUNT) begin
      s_d.count = reg_wdata;
    end

    // Sticky status: write one to clear, a same-cycle event wins
    if (wr_stat) begin
      s_d.stat = s_q.stat & ~reg_wdata[TMCU_NIRQ-1:0];
    end
    s_d.stat = s_d.stat | set;
    s_d.irq = |(s_d.stat & s_d.mask);

    // Read data stands only in the cycle after the strobe
    s_d.rdata = TMCU_ZERO32;
    if (reg_rd) begin
      case (reg_addr)
        TMCU_A_CTRL: s_d.rdata = 32'(s_q.ctrl);
        TMCU_A_COUNT: s_d.rdata = s_q.count;
        TMCU_A_PRESCALE: s_d.rdata = s_q.prescale;
        TMCU_A_PRECOUNT: s_d.rdata = s_q.precount;
        TMCU_A_MATCH_CTRL: s_d.rdata = 32'(s_q.mctrl);
        TMCU_A_OUT_CTRL: s_d.rdata = 32'({s_q.mout, s_q.octrl});
        TMCU_A_CAP_CTRL: s_d.rdata = 32'(s_q.cctrl);
        TMCU_A_PWM_CTRL: s_d.rdata = 32'(s_q.pwm);
        TMCU_A_IRQ_STAT: s_d.rdata = 32'(s_q.stat);
        TMCU_A_IRQ_MASK: s_d.rdata = 32'(s_q.mask);
        default: s_d.rdata = TMCU_ZERO32;
      endcase
      for (int i = 0; i < TMCU_NMATCH; i++) begin
        if (reg_addr == 8'(TMCU_A_MATCH0 + TMCU_A_STEP * i)) begin
          s_d.rdata = s_q.mshadow[i];
        end
      end
      for (int j = 0; j < TMCU_NCAP; j++) begin
        if (reg_addr == 8'(TMCU_A_CAP0 + TMCU_A_STEP * j)) begin
          s_d.rdata = s_q.cap[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign match_out = s_q.mout;
  assign dma_req = s_q.dma;
  assign irq = s_q.irq;

endmodule

// File: verification/tb_top.sv
// Self-checking bench of the match/capture timer with a DMA stand-in.
// Assumes the register map and timing of the timer package.
`timescale 1ns/1ps
module tb_top;
  import tmcu_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [TMCU_AW-1:0] reg_addr = '0;
  logic [TMCU_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [TMCU_DW-1:0] reg_rdata;
  logic ext_clk_in = 1'b0;
  logic [TMCU_NCAP-1:0] cap_in = '0;
  logic [TMCU_NMATCH-1:0] match_out;
  logic [TMCU_NDMA-1:0] dma_req;
  logic [TMCU_NDMA-1:0] dma_ack;
  logic irq;
  logic slow = 1'b0;
  logic [31:0] d;
  int fails = 0;
  int samples_checked = 0;
  tmcu_top dut_u (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_clk_in, .cap_in, .match_out, .dma_req, .dma_ack, .irq);
  tmcu_far_model far_u (.core_clk, .reset, .slow, .dma_req, .dma_ack);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [TMCU_AW-1:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [TMCU_AW-1:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    cap_in <= '0;
    ext_clk_in <= 1'b0;
    slow <= 1'b0;
    tick(10);
    reset <= 1'b0;
  endtask
  task automatic summarize();
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_match_reset();
    bit seen_req;
    bit seen_req1;
    seen_req = 1'b0;
    seen_req1 = 1'b0;
    do_reset();
    rd(TMCU_A_CTRL, d);
    chk(d, TMCU_ZERO32, "ctrl reset value");
    rd(8'h40, d);
    chk(d, TMCU_ZERO32, "unmapped read");
    wr(TMCU_A_MATCH0, 32'h0000_0002);
    // Match 1 stays at zero, so its DMA request fires once per period
    wr(TMCU_A_MATCH_CTRL, 32'h0000_3003);
    wr(TMCU_A_OUT_CTRL, 32'h0000_0002);
    wr(TMCU_A_IRQ_MASK, TMCU_ONE32);
    wr(TMCU_A_CTRL, TMCU_ONE32);
    repeat (24) begin
      tick(1);
      if (dma_req[0] === 1'b1) seen_req = 1'b1;
      if (dma_req[1] === 1'b1) seen_req1 = 1'b1;
      slow <= 1'b1;
    end
    chk(32'(seen_req), 32'h1, "no dma request");
    chk(32'(seen_req1), 32'h1, "no dma request 1");
    chk(32'(irq), 32'h1, "match irq missing");
    chk(32'(match_out[0]), 32'h1, "pin not set high");
    wr(TMCU_A_CTRL, TMCU_ZERO32);
    rd(TMCU_A_COUNT, d);
    chk(32'(d <= 32'h2), 32'h1, "count passed match");
    wr(TMCU_A_IRQ_STAT, TMCU_ONE32);
    rd(TMCU_A_IRQ_STAT, d);
    chk(d, TMCU_ZERO32, "status not cleared");
    chk(32'(irq), 32'h0, "irq stuck");
  endtask
  task automatic s_stop_pins();
    // Each pin action in turn; a single match must leave its mark
    for (int a = 0; a < 4; a++) begin
      do_reset();
      wr(TMCU_A_PRESCALE, TMCU_ONE32);
      wr(TMCU_A_MATCH0 + 8'h04, 32'h0000_0005);
      wr(TMCU_A_MATCH_CTRL, 32'hFFFF_C028);
      wr(TMCU_A_OUT_CTRL, 32'(a) << 2);
      wr(TMCU_A_CTRL, TMCU_ONE32);
      tick(30);
      rd(TMCU_A_COUNT, d);
      chk(d, 32'h0000_0005, "count not held");
      rd(TMCU_A_CTRL, d);
      chk(d, TMCU_ZERO32, "enable not cleared");
      rd(TMCU_A_IRQ_STAT, d);
      chk(d, 32'h0000_0002, "stop irq missing");
      chk(32'(match_out[1]), 32'(a >= 2), "pin action");
      rd(TMCU_A_OUT_CTRL, d);
      chk(d, (32'(a >= 2) << 9) | (32'(a) << 2), "pin readback");
      rd(TMCU_A_MATCH_CTRL, d);
      chk(d, 32'h0000_0028, "match control readback");
    end
  endtask
  task automatic s_capture();
    do_reset();
    wr(TMCU_A_COUNT, 32'h0000_1234);
    wr(TMCU_A_CAP_CTRL, 32'hFFFF_FC0D);
    wr(TMCU_A_IRQ_MASK, 32'h0000_0010);
    cap_in <= 2'b11;
    tick(8);
    rd(TMCU_A_CAP0, d);
    chk(d, 32'h0000_1234, "capture value");
    chk(32'(irq), 32'h1, "capture irq");
    rd(TMCU_A_CAP0 + 8'h04, d);
    chk(d, 32'h0000_1234, "capture 1 value");
    rd(TMCU_A_CAP_CTRL, d);
    chk(d, 32'h0000_000D, "capture control readback");
    wr(TMCU_A_COUNT, 32'h0000_0077);
    cap_in[0] <= 1'b0;
    tick(8);
    rd(TMCU_A_CAP0, d);
    chk(d, 32'h0000_1234, "falling edge captured");
    wr(TMCU_A_IRQ_MASK, TMCU_ZERO32);
    tick(2);
    chk(32'(irq), 32'h0, "masked irq");
    wr(TMCU_A_CAP_CTRL, 32'h0000_00C1);
    cap_in[0] <= 1'b1;
    tick(8);
    rd(TMCU_A_COUNT, d);
    chk(d, TMCU_ZERO32, "count not cleared");
    rd(TMCU_A_CAP0, d);
    chk(d, 32'h0000_0077, "capture before clear");
  endtask
  task automatic s_ext_count();
    do_reset();
    wr(TMCU_A_CTRL, 32'h0000_000D);
    repeat (5) begin
      tick(5);
      ext_clk_in <= 1'b1;
      tick(5);
      ext_clk_in <= 1'b0;
    end
    tick(5);
    rd(TMCU_A_COUNT, d);
    chk(d, 32'h0000_0005, "external edge count");
    // Falling edges only: the rise below must not count
    wr(TMCU_A_CTRL, 32'h0000_0015);
    ext_clk_in <= 1'b1;
    tick(5);
    ext_clk_in <= 1'b0;
    tick(5);
    rd(TMCU_A_COUNT, d);
    chk(d, 32'h0000_0006, "external falling count");
    wr(TMCU_A_CTRL, 32'h0000_0002);
    rd(TMCU_A_COUNT, d);
    chk(d, TMCU_ZERO32, "hold-reset count");
  endtask
  task automatic s_pwm();
    // Duty is counted over whole periods, so the phase of sampling does not matter
    int highs;
    do_reset();
    wr(TMCU_A_MATCH0 + 8'h0C, 32'h0000_0009);
    wr(TMCU_A_MATCH0, 32'h0000_0004);
    wr(TMCU_A_PWM_CTRL, 32'hFFFF_FFF9);
    wr(TMCU_A_CTRL, TMCU_ONE32);
    for (int r = 0; r < 2; r++) begin
      tick(20);
      highs = 0;
      repeat (30) begin
        tick(1);
        if (match_out[0] === 1'b1) highs++;
      end
      chk(32'(highs), (r == 0) ? 32'h0000_000F : 32'h0000_0009, "pwm duty");
      wr(TMCU_A_MATCH0, 32'h0000_0006);
    end
    rd(TMCU_A_PWM_CTRL, d);
    chk(d, TMCU_ONE32, "pwm control readback");
  endtask
  initial begin
    s_match_reset();
    s_stop_pins();
    s_capture();
    s_ext_count();
    s_pwm();
    summarize();
  end
  initial begin
    repeat (10000) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule

// File: verification/tmcu_far_model.sv
// DMA controller stand-in: acknowledges each timed request of the timer.
// Assumes requests are levels held until acknowledged.
`timescale 1ns/1ps
module tmcu_far_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // High for a slow acknowledge
  input wire logic slow,
  // DMA handshake
  input wire logic [tmcu_pkg::TMCU_NDMA-1:0] dma_req,
  output logic [tmcu_pkg::TMCU_NDMA-1:0] dma_ack
);
  import tmcu_pkg::*;
  logic [2:0] wait_q [TMCU_NDMA];
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < TMCU_NDMA; k++) begin
      if (reset || !dma_req[k] || dma_ack[k]) begin
        wait_q[k] <= 3'h0;
        dma_ack[k] <= 1'b0;
      end else if (wait_q[k] >= (slow ? 3'h4 : 3'h1)) begin
        dma_ack[k] <= 1'b1;
      end else begin
        wait_q[k] <= wait_q[k] + 3'h1;
      end
    end
  end
endmodule

// File: verification/tmcu_sva.sv
// Port checker of the match/capture timer.
// Assumes one clock domain; bound onto the top module below.
`timescale 1ns/1ps
module tmcu_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [tmcu_pkg::TMCU_AW-1:0] reg_addr,
  input wire logic [tmcu_pkg::TMCU_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tmcu_pkg::TMCU_DW-1:0] reg_rdata,
  // Pins and handshake
  input wire logic ext_clk_in,
  input wire logic [tmcu_pkg::TMCU_NCAP-1:0] cap_in,
  input wire logic [tmcu_pkg::TMCU_NMATCH-1:0] match_out,
  input wire logic [tmcu_pkg::TMCU_NDMA-1:0] dma_req,
  input wire logic [tmcu_pkg::TMCU_NDMA-1:0] dma_ack,
  input wire logic irq
);
  import tmcu_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----
  // Assertions
  // ----
  sequence mask_cut_s;
    reg_wr && reg_addr == TMCU_A_IRQ_MASK && reg_wdata == '0;
  endsequence
  out_reset_a: assert property ($fell(reset) |-> !irq && match_out == '0 && dma_req == '0)
    else $error("outputs not clear after reset");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");
  pin_read_a: assert property (reg_rd && reg_addr == TMCU_A_OUT_CTRL
    |=> reg_rdata[11:8] == $past(match_out) && reg_rdata[31:12] == '0)
    else $error("pin readback wrong");
  mctl_width_a: assert property (reg_rd && reg_addr == TMCU_A_MATCH_CTRL
    |=> reg_rdata[31:14] == '0) else $error("match control upper bits set");
  cctl_width_a: assert property (reg_rd && reg_addr == TMCU_A_CAP_CTRL
    |=> reg_rdata[31:10] == '0) else $error("capture control upper bits set");
  pwm_width_a: assert property (reg_rd && reg_addr == TMCU_A_PWM_CTRL
    |=> reg_rdata[31:3] == '0) else $error("pwm control upper bits set");
  mask_off_a: assert property (mask_cut_s ##1 !(reg_wr && reg_addr == TMCU_A_IRQ_MASK)
    |=> !irq) else $error("irq high with all masked");
  hold_zero_a: assert property (reg_wr && reg_addr == TMCU_A_CTRL && reg_wdata[TMCU_CT_RST]
    ##1 !reg_wr ##1 (!reg_wr && reg_rd && reg_addr == TMCU_A_COUNT) |=> reg_rdata == '0)
    else $error("count not held at zero");
  dma_hold0_a: assert property (dma_req[0] && !dma_ack[0] |=> dma_req[0])
    else $error("dma request 0 dropped early");
  dma_hold1_a: assert property (dma_req[1] && !dma_ack[1] |=> $stable(dma_req[1]))
    else $error("dma request 1 dropped early");
  irq_c: cover property ($rose(irq));
  dma_c: cover property ($rose(dma_req[0]));
  pin_c: cover property ($rose(match_out[0]));
endmodule
bind tmcu_top tmcu_sva chk_u (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ext_clk_in, .cap_in, .match_out, .dma_req, .dma_ack, .irq);
